// ==== include/adcs_map.svh ====
// adcs_map.svh: offsets, field positions, reset values and timing counts
// of the converter sequencer; definitions only, included by bare name.
`ifndef ADCS_MAP_SVH
`define ADCS_MAP_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define ADCS_OFF_CTRL0    4'h0
`define ADCS_OFF_CTRL1    4'h1
`define ADCS_OFF_RES_HI   4'h2
`define ADCS_OFF_RES_LO   4'h3
`define ADCS_OFF_IRQ_STAT 4'h4
`define ADCS_OFF_IRQ_CLR  4'h5
`define ADCS_OFF_IRQ_EN   4'h6

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define ADCS_CTRL0_START  7
`define ADCS_CTRL0_BUSY   6
`define ADCS_CTRL0_PWR    5
`define ADCS_IRQ_DONE     0
`define ADCS_IRQ_GLOBAL   7
`define ADCS_CTRL0_RST    8'h00
`define ADCS_CTRL1_RST    3'h0
`define ADCS_IRQ_EN_RST   8'h00

// ----------------------------------------------------------------------
// conversion timing in conversion clock periods
// ----------------------------------------------------------------------
`define ADCS_SAMPLE_PERIODS  4'h4
`define ADCS_CONVERT_PERIODS 4'hC

`endif

// ==== include/adcs_pkg.sv ====
// adcs_pkg: types shared by the converter sequencer.
// assumes adcs_map.svh is on the include path.
package adcs_pkg;

    // sequencer states
    typedef enum logic [1:0] {
        ADCS_IDLE,
        ADCS_HOLD,
        ADCS_SAMPLE,
        ADCS_CONVERT
    } adcs_state_t;

    // lines toward the analog core
    typedef struct packed {
        logic        power;   // converter power enable
        logic        sample;  // sampling switch closed
        logic [11:0] dac;     // trial code of the approximation
    } adcs_ana_t;

endpackage

// ==== design/adcs_sequencer.sv ====
// adcs_sequencer: register port, clock divider, sampling and successive
// approximation sequencer and interrupt logic of a 12-bit converter.
// assumes a comparator answer cmp_i synchronous to ref_clk_i, high when
// the input is at or above the trial code on ana_o.dac.
//
// Chosen here: the strobed register port and the address map.
`include "adcs_map.svh"
`timescale 1ns/1ps
`default_nettype none

module adcs_sequencer
    import adcs_pkg::*;
#(
    parameter int DIV_W = 7                   // divider width, up to /128
)(
    input  wire logic        ref_clk_i,      // 40 MHz system clock
    input  wire logic        sys_rst_i,      // async reset, active high
    input  wire logic [3:0]  addr_i,         // register address
    input  wire logic [7:0]  wdata_i,        // write data
    input  wire logic        wr_i,           // write strobe
    input  wire logic        rd_i,           // read strobe
    output logic      [7:0]  rdata_o,        // read data, cycle after rd
    input  wire logic        cmp_i,          // comparator answer
    output adcs_ana_t        ana_o,          // analog core control
    output logic             irq_o           // level interrupt
);

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------
    logic       start, next_start;
    logic       pwr, next_pwr;
    logic [2:0] div_sel, next_div_sel;
    logic       cie, next_cie;
    logic       gie, next_gie;
    logic       irq_stat, next_irq_stat;
    logic [7:0] rdata, next_rdata;

    // ------------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------------
    adcs_state_t      state, next_state;
    logic [3:0]       phase, next_phase;
    logic [11:0]      sar, next_sar;
    logic [11:0]      bitm, next_bitm;
    logic [11:0]      result, next_result;
    logic             busy, next_busy;
    logic [DIV_W-1:0] div_cnt, next_div_cnt;
    logic [DIV_W-1:0] div_top;
    logic             tick;
    logic             done;
    logic [11:0]      trial;

    // register writes and interrupt flag; set wins over clear
    always_comb
    begin
        next_start    = start;
        next_pwr      = pwr;
        next_div_sel  = div_sel;
        next_cie      = cie;
        next_gie      = gie;
        next_irq_stat = irq_stat;
        if (wr_i && addr_i == `ADCS_OFF_CTRL0)
        begin
            next_start = wdata_i[`ADCS_CTRL0_START];
            next_pwr   = wdata_i[`ADCS_CTRL0_PWR];
        end
        else if (wr_i && addr_i == `ADCS_OFF_CTRL1)
        begin
            next_div_sel = wdata_i[2:0];
        end
        else if (wr_i && addr_i == `ADCS_OFF_IRQ_EN)
        begin
            next_cie = wdata_i[`ADCS_IRQ_DONE];
            next_gie = wdata_i[`ADCS_IRQ_GLOBAL];
        end
        else if (wr_i && addr_i == `ADCS_OFF_IRQ_CLR)
        begin
            if (wdata_i[`ADCS_IRQ_DONE])
            begin
                next_irq_stat = 1'b0;
            end
        end
        if (done)
        begin
            next_irq_stat = 1'b1;
        end
    end

    // read mux; unmapped and write-only offsets read as zero
    always_comb
    begin
        next_rdata = 8'h00;
        if (!rd_i)
        begin
            next_rdata = 8'h00;
        end
        else if (addr_i == `ADCS_OFF_CTRL0)
        begin
            next_rdata[`ADCS_CTRL0_START] = start;
            next_rdata[`ADCS_CTRL0_BUSY]  = busy;
            next_rdata[`ADCS_CTRL0_PWR]   = pwr;
        end
        else if (addr_i == `ADCS_OFF_CTRL1)
        begin
            next_rdata[2:0] = div_sel;
        end
        else if (addr_i == `ADCS_OFF_RES_HI)
        begin
            next_rdata[3:0] = result[11:8];
        end
        else if (addr_i == `ADCS_OFF_RES_LO)
        begin
            next_rdata = result[7:0];
        end
        else if (addr_i == `ADCS_OFF_IRQ_STAT)
        begin
            next_rdata[`ADCS_IRQ_DONE] = irq_stat;
        end
        else if (addr_i == `ADCS_OFF_IRQ_EN)
        begin
            next_rdata[`ADCS_IRQ_DONE]   = cie;
            next_rdata[`ADCS_IRQ_GLOBAL] = gie;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            start    <= 1'(`ADCS_CTRL0_RST >> `ADCS_CTRL0_START);
            pwr      <= 1'b0;
            div_sel  <= `ADCS_CTRL1_RST;
            cie      <= 1'b0;
            gie      <= 1'b0;
            irq_stat <= 1'b0;
            rdata    <= 8'h00;
        end
        else
        begin
            start    <= next_start;
            pwr      <= next_pwr;
            div_sel  <= next_div_sel;
            cie      <= next_cie;
            gie      <= next_gie;
            irq_stat <= next_irq_stat;
            rdata    <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // conversion clock divider and sequencer
    // ------------------------------------------------------------------
    // the divider restarts with each conversion so every phase is whole
    assign div_top = DIV_W'((8'h01 << div_sel) - 8'h01);
    assign tick    = (div_cnt >= div_top);      // no wrap if code drops
    assign trial   = cmp_i ? sar : (sar & ~bitm);
    assign done    = (state == ADCS_CONVERT) && tick && bitm[0];

    always_comb
    begin
        next_state   = state;
        next_phase   = phase;
        next_sar     = sar;
        next_bitm    = bitm;
        next_result  = result;
        next_busy    = busy;
        next_div_cnt = (tick || state == ADCS_HOLD) ? '0
                     : DIV_W'(div_cnt + 1'b1);
        case (state)
            ADCS_IDLE:
            begin
                if (start)
                begin
                    next_state = ADCS_HOLD;
                end
            end
            ADCS_HOLD:
            begin
                if (!start)
                begin
                    next_state = ADCS_SAMPLE;
                    next_busy  = 1'b1;
                    next_phase = 4'h0;
                    next_sar   = 12'h000;
                end
            end
            ADCS_SAMPLE:
            begin
                if (tick)
                begin
                    next_phase = phase + 4'h1;
                    if (phase == `ADCS_SAMPLE_PERIODS - 4'h1)
                    begin
                        next_state = ADCS_CONVERT;
                        next_phase = 4'h0;
                        next_bitm  = 12'h800;
                        next_sar   = 12'h800;
                    end
                end
            end
            ADCS_CONVERT:
            begin
                if (tick)
                begin
                    // one result bit decided per conversion period
                    next_phase = phase + 4'h1;
                    next_bitm  = bitm >> 1;
                    next_sar   = trial | (bitm >> 1);
                    if (bitm[0])
                    begin
                        next_state  = ADCS_IDLE;
                        next_result = trial;
                        next_busy   = 1'b0;
                    end
                end
            end
            default:
            begin
                next_state = ADCS_IDLE;
            end
        endcase
        // a start bit raised mid-conversion resets the sequencer
        if (start && state != ADCS_IDLE)
        begin
            next_state = ADCS_HOLD;
            next_busy  = 1'b0;
        end
        // powered down: ignore start, stay idle, busy stays low
        if (!pwr)
        begin
            next_state = ADCS_IDLE;
            next_busy  = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state   <= ADCS_IDLE;
            phase   <= 4'h0;
            sar     <= 12'h000;
            bitm    <= 12'h000;
            result  <= 12'h000;
            busy    <= 1'b0;
            div_cnt <= '0;
        end
        else
        begin
            state   <= next_state;
            phase   <= next_phase;
            sar     <= next_sar;
            bitm    <= next_bitm;
            result  <= next_result;
            busy    <= next_busy;
            div_cnt <= next_div_cnt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign rdata_o      = rdata;
    assign ana_o.power  = pwr;
    assign ana_o.sample = (state == ADCS_SAMPLE);
    assign ana_o.dac    = sar;
    assign irq_o        = irq_stat && cie && gie;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    busy_on_start_a: assert property (
        (state == ADCS_HOLD && !start && pwr) |=> busy && ana_o.sample)
        else $error("busy not set at conversion start");
    busy_off_done_a: assert property (
        done && pwr && !start |=> !busy && state == ADCS_IDLE)
        else $error("busy not cleared at completion");
    irq_flag_set_a: assert property (
        done |=> irq_stat)
        else $error("request flag missing after completion");
    irq_gate_a: assert property (
        (done && cie && gie && !wr_i) |=> irq_o)
        else $error("enabled completion raised no interrupt");
    div_full_rate_a: assert property (
        (div_sel == 3'h0) |-> tick)
        else $error("undivided clock missed a period");
    div_by_two_a: assert property (
        (div_sel == 3'h1 && state == ADCS_SAMPLE && tick &&
         $stable(div_sel)) |=> !tick ##1 tick)
        else $error("divide by two spacing wrong");
    sample_len_a: assert property (
        (state == ADCS_CONVERT && $past(state) == ADCS_SAMPLE)
        |-> $past(phase) == 4'h3)
        else $error("sampling phase not four periods");
    convert_len_a: assert property (
        done |-> phase == `ADCS_CONVERT_PERIODS - 4'h1)
        else $error("conversion phase not twelve periods");
    power_idle_a: assert property (
        !pwr |=> state == ADCS_IDLE && !busy)
        else $error("sequencer active while powered down");
    start_reset_a: assert property (
        (start && pwr && state != ADCS_IDLE) |=> state == ADCS_HOLD)
        else $error("start high did not hold sequencer");
    result_hold_a: assert property (
        !done |=> $stable(result))
        else $error("result changed without completion");

    conv_done_c: cover property (done);
    irq_raise_c: cover property (done ##1 irq_o);
    restart_c:   cover property (state == ADCS_CONVERT && start);

endmodule

`default_nettype wire

// ==== dv/adcs_sequencer_test.sv ====
// adcs_sequencer_test: self-checking bench of the converter sequencer.
// assumes adcs_pkg and adcs_map.svh are compiled first; the comparator
// is an ideal compare of a bench target code against the trial code.
`include "adcs_map.svh"
`timescale 1ns/1ps
`default_nettype none

module adcs_sequencer_test
    import adcs_pkg::*;
;
    logic        ref_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [3:0]  addr_i    = 4'h0;
    logic [7:0]  wdata_i   = 8'h00;
    logic        wr_i      = 1'b0;
    logic        rd_i      = 1'b0;
    logic [7:0]  rdata_o;
    logic        cmp_i;
    adcs_ana_t   ana_o;
    logic        irq_o;
    logic [11:0] target    = 12'h000;
    logic [31:0] seed      = 32'h394d_8939;
    logic [7:0]  d;
    int          err_count = 0;
    int          samples_checked = 0;
    int          c;
    logic [11:0] corner [4] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF};

    // ----------------------------------------------------------------
    // clock, comparator and design
    // ----------------------------------------------------------------
    // 40 MHz system clock
    always #12.5 ref_clk_i = ~ref_clk_i;
    // ideal comparator: answers at once, so no lag against the trial code
    assign cmp_i = (target >= ana_o.dac);

    adcs_sequencer u_adcs_sequencer (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .addr_i    (addr_i),
        .wdata_i   (wdata_i),
        .wr_i      (wr_i),
        .rd_i      (rd_i),
        .rdata_o   (rdata_o),
        .cmp_i     (cmp_i),
        .ana_o     (ana_o),
        .irq_o     (irq_o)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // look one step past the edge so its updates have landed
    task automatic tick();
        @(posedge ref_clk_i);
        #1;
    endtask

    // one-cycle strobes; a spare edge between calls keeps one driver
    task automatic bus_wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge ref_clk_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic bus_rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        rd_i   <= 1'b0;
        #1;
        v = rdata_o;
    endtask

    task automatic start_pulse();
        bus_wr(`ADCS_OFF_CTRL0, 8'hA0);
        bus_wr(`ADCS_OFF_CTRL0, 8'h20);
    endtask

    // time both phases, then result, busy and request
    task automatic measure(input logic [2:0] n);
        c = 0;
        while (ana_o.sample !== 1'b1 && c < 8)
        begin
            tick();
            c++;
        end
        c = 0;
        while (ana_o.sample === 1'b1 && c < 600)
        begin
            c++;
            tick();
        end
        check(16'(c), 16'(4 << n));
        c = 0;
        while (irq_o !== 1'b1 && c < 2000)
        begin
            tick();
            c++;
        end
        check(16'(c), 16'(12 << n));
        bus_rd(`ADCS_OFF_RES_HI, d);
        check(d, {4'h0, target[11:8]});
        bus_rd(`ADCS_OFF_RES_LO, d);
        check(d, target[7:0]);
        bus_rd(`ADCS_OFF_CTRL0, d);
        check(d, 8'h20);
        bus_rd(`ADCS_OFF_IRQ_STAT, d);
        check(d, 8'h01);
        bus_wr(`ADCS_OFF_IRQ_CLR, 8'h01);
        tick();
        check(irq_o, 1'b0);
    endtask

    task automatic run_conv(input logic [2:0] n, input logic [11:0] t);
        bus_wr(`ADCS_OFF_CTRL1, {5'h00, n});
        target <= t;
        bus_rd(`ADCS_OFF_CTRL1, d);
        check(d, {5'h00, n});
        start_pulse();
        measure(n);
    endtask

    task automatic test_done();
        if (err_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        tick();
        check(irq_o, 1'b0);
        check(ana_o.power, 1'b0);
        bus_rd(`ADCS_OFF_CTRL0, d);
        check(d, 8'h00);
        bus_rd(`ADCS_OFF_IRQ_EN, d);
        check(d, 8'h00);
        bus_rd(4'hF, d);
        check(d, 8'h00);
        // start while unpowered must leave the sequencer idle
        bus_wr(`ADCS_OFF_CTRL0, 8'h80);
        bus_wr(`ADCS_OFF_CTRL0, 8'h00);
        for (int i = 0; i < 24; i++)
        begin
            tick();
            check(ana_o.sample, 1'b0);
        end
        bus_rd(`ADCS_OFF_CTRL0, d);
        check(d, 8'h00);
        bus_wr(`ADCS_OFF_CTRL0, 8'h60);
        tick();
        check(ana_o.power, 1'b1);
        bus_rd(`ADCS_OFF_CTRL0, d);
        check(d, 8'h20);
        repeat (40) tick(); // settling wait before the first start
        bus_wr(`ADCS_OFF_IRQ_EN, 8'h81);
        // every divider code with a random target; at 40 MHz only codes
        // 3'h5..3'h7 keep the period in range, but every code checks timing and result
        for (int n = 0; n < 8; n++)
        begin
            seed = xs(seed);
            run_conv(3'(n), seed[11:0]);
        end
        // corner codes of the approximation at the undivided clock
        foreach (corner[i])
            run_conv(3'h0, corner[i]);
        // abort by raising start mid conversion, then restart
        seed = xs(seed);
        start_pulse();
        target <= seed[11:0];
        repeat (3) tick();
        bus_rd(`ADCS_OFF_CTRL0, d);
        check(d, 8'h60);
        bus_wr(`ADCS_OFF_CTRL0, 8'hA0);
        bus_rd(`ADCS_OFF_CTRL0, d);
        check(d, 8'hA0);
        for (int i = 0; i < 30; i++)
        begin
            tick();
            check(irq_o, 1'b0);
        end
        bus_wr(`ADCS_OFF_CTRL0, 8'h20);
        measure(3'h0);
        // global enable off: poll busy, request pends without irq
        bus_wr(`ADCS_OFF_IRQ_EN, 8'h01);
        start_pulse();
        c = 0;
        d = 8'h40;
        while (d[6] !== 1'b0 && c < 40)
        begin
            bus_rd(`ADCS_OFF_CTRL0, d);
            c++;
        end
        check(d, 8'h20);
        check(irq_o, 1'b0);
        bus_rd(`ADCS_OFF_IRQ_STAT, d);
        check(d, 8'h01);
        bus_wr(`ADCS_OFF_IRQ_EN, 8'h81);
        tick();
        check(irq_o, 1'b1);
        bus_wr(`ADCS_OFF_IRQ_CLR, 8'h01);
        tick();
        check(irq_o, 1'b0);
        bus_wr(`ADCS_OFF_CTRL0, 8'h00);
        tick();
        check(ana_o.power, 1'b0);
        test_done();
    end

    // watchdog: the whole sequence needs well under 20000 cycles
    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        err_count++;
        test_done();
    end
endmodule

`default_nettype wire
